// ### asrc_pkg.sv
// package: pin timing constants and types for the async sram host controller
`default_nettype none
package asrc_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int DEPTH  = 32768;

	// ****************************************
	// timing, ns as printed for the fastest grade
	// ****************************************
	localparam int CLK_PERIOD_NS        = 50;
	localparam int CYCLE_TIME_NS        = 12;
	localparam int ADDRESS_ACCESS_NS    = 12;
	localparam int GATE_ACCESS_NS       = 6;
	localparam int GATE_FLOAT_NS        = 6;
	localparam int ENABLE_FLOAT_NS      = 7;
	localparam int ADDR_TO_STROBE_END_NS = 10;
	localparam int WRITE_DATA_SETUP_NS  = 6;
	localparam int STROBE_HIGH_DRIVE_NS = 2;

	// least times round up, never below one cycle
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int READ_WAIT_CYC  = min_cycles(ADDRESS_ACCESS_NS + 2 * CLK_PERIOD_NS);
	localparam int STROBE_CYC     = min_cycles(ADDR_TO_STROBE_END_NS);
	localparam int FLOAT_CYC      = min_cycles(ENABLE_FLOAT_NS);
	localparam int RECOVER_CYC    = min_cycles(CYCLE_TIME_NS);
	localparam int CNT_W          = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_RDONE = 3'b010,
		ST_WSET  = 3'b011,
		ST_WSTB  = 3'b100,
		ST_WHOLD = 3'b101,
		ST_FLOAT = 3'b110
	} asrc_state_t;
endpackage : asrc_pkg
`default_nettype wire

// ### asrc_pin_if.sv
// interface: sram pin group between the sequencer and the pin stage
`default_nettype none
interface asrc_pin_if;
	logic [asrc_pkg::ADDR_W-1:0] addr;
	logic                        cs_n;
	logic                        gate_n;
	logic                        strobe_n;
	logic [asrc_pkg::DATA_W-1:0] wdata;
	logic                        drive;
	logic [asrc_pkg::DATA_W-1:0] rdata;
	modport seq (output addr, cs_n, gate_n, strobe_n, wdata, drive, input rdata);
	modport pin (input addr, cs_n, gate_n, strobe_n, wdata, drive, output rdata);
endinterface : asrc_pin_if
`default_nettype wire

// ### asrc_pin_stage.sv
// module: registered pin drivers and two-flop sync of the read bus
`default_nettype none
module asrc_pin_stage (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_reset_n,
	asrc_pin_if.pin                          pins,
	input  wire logic [asrc_pkg::DATA_W-1:0] i_dq_in,
	output logic      [asrc_pkg::DATA_W-1:0] o_dq_out,
	output logic      [asrc_pkg::DATA_W-1:0] o_dq_oe,
	output logic      [asrc_pkg::ADDR_W-1:0] o_addr,
	output logic                             o_cs_n,
	output logic                             o_gate_n,
	output logic                             o_strobe_n
);
	typedef struct packed {
		logic [asrc_pkg::DATA_W-1:0] sync1;
		logic [asrc_pkg::DATA_W-1:0] sync2;
		logic [asrc_pkg::DATA_W-1:0] dout;
		logic [asrc_pkg::DATA_W-1:0] oe;
		logic [asrc_pkg::ADDR_W-1:0] addr;
		logic                        cs_n;
		logic                        gate_n;
		logic                        strobe_n;
	} asrc_pin_st_t;

	asrc_pin_st_t st_ff;
	asrc_pin_st_t nxt_st;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_st          = st_ff;
		nxt_st.sync1    = i_dq_in;
		nxt_st.sync2    = st_ff.sync1;
		nxt_st.dout     = pins.wdata;
		nxt_st.oe       = {asrc_pkg::DATA_W{pins.drive}};
		nxt_st.addr     = pins.addr;
		nxt_st.cs_n     = pins.cs_n;
		nxt_st.gate_n   = pins.gate_n;
		nxt_st.strobe_n = pins.strobe_n;
		if (!i_reset_n) begin
			nxt_st          = '0;
			nxt_st.cs_n     = 1'b1;
			nxt_st.gate_n   = 1'b1;
			nxt_st.strobe_n = 1'b1; // strobe high outside writes
		end
	end

	// state register
	always_ff @(posedge i_core_clk) begin
		st_ff <= nxt_st;
	end

	assign pins.rdata = st_ff.sync2;
	assign o_dq_out   = st_ff.dout;
	assign o_dq_oe    = st_ff.oe;
	assign o_addr     = st_ff.addr;
	assign o_cs_n     = st_ff.cs_n;
	assign o_gate_n   = st_ff.gate_n;
	assign o_strobe_n = st_ff.strobe_n;
endmodule : asrc_pin_stage
`default_nettype wire

// ### asrc_host.sv
// module: host controller sequencing read and strobe-controlled write cycles
// Contract
// - host keeps strobe high during reads
// - address valid before select falls; host sets both on the same edge
// - host spaces cycles at least 12 ns
// - address set before strobe, 10 ns to end
// - data 6 ns before strobe rises, 0 hold
// - host gives minimums, memory gives maximums
`default_nettype none
module asrc_host (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_req_valid,
	input  wire logic                        i_req_write,
	input  wire logic [asrc_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic [asrc_pkg::DATA_W-1:0] i_req_wdata,
	output logic                             o_req_ready,
	output logic                             o_rsp_valid,
	output logic      [asrc_pkg::DATA_W-1:0] o_rsp_rdata,
	output logic      [asrc_pkg::ADDR_W-1:0] o_sram_addr,
	output logic                             o_sram_cs_n,
	output logic                             o_sram_gate_n,
	output logic                             o_sram_strobe_n,
	input  wire logic [asrc_pkg::DATA_W-1:0] i_sram_dq,
	output logic      [asrc_pkg::DATA_W-1:0] o_sram_dq,
	output logic      [asrc_pkg::DATA_W-1:0] o_sram_dq_oe
);
	typedef struct packed {
		asrc_pkg::asrc_state_t       state;
		logic [asrc_pkg::CNT_W-1:0]  cnt;
		logic [asrc_pkg::ADDR_W-1:0] addr;
		logic [asrc_pkg::DATA_W-1:0] wdata;
		logic                        cs_n;
		logic                        gate_n;
		logic                        strobe_n;
		logic                        drive;
		logic                        rsp_valid;
		logic [asrc_pkg::DATA_W-1:0] rdata;
	} asrc_host_st_t;

	localparam logic [asrc_pkg::CNT_W-1:0] READ_WAIT = asrc_pkg::CNT_W'(asrc_pkg::READ_WAIT_CYC);
	localparam logic [asrc_pkg::CNT_W-1:0] STROBE_W  = asrc_pkg::CNT_W'(asrc_pkg::STROBE_CYC);
	localparam logic [asrc_pkg::CNT_W-1:0] FLOAT_W   = asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC);
	localparam logic [asrc_pkg::CNT_W-1:0] RECOVER_W = asrc_pkg::CNT_W'(asrc_pkg::RECOVER_CYC);
	localparam logic [asrc_pkg::CNT_W-1:0] CNT_ONE   = asrc_pkg::CNT_W'(1);

	asrc_host_st_t st_ff;
	asrc_host_st_t nxt_st;
	asrc_pin_if    pins ();

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		nxt_st           = st_ff;
		nxt_st.rsp_valid = 1'b0;
		case (st_ff.state)
			asrc_pkg::ST_IDLE: begin
				if (i_req_valid) begin
					nxt_st.addr = i_req_addr; // address set on the same edge that select falls
					nxt_st.wdata = i_req_wdata;
					nxt_st.cs_n = 1'b0;
					if (i_req_write) begin
						nxt_st.state = asrc_pkg::ST_WSET; // gate stays high so bus floats
					end else begin
						nxt_st.gate_n = 1'b0; // read with strobe held high
						nxt_st.cnt    = READ_WAIT; // covers access plus pin and sync flops
						nxt_st.state  = asrc_pkg::ST_READ;
					end
				end
			end
			asrc_pkg::ST_READ: begin
				if (st_ff.cnt == CNT_ONE) begin
					nxt_st.state = asrc_pkg::ST_RDONE;
				end else begin
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				end
			end
			asrc_pkg::ST_RDONE: begin
				nxt_st.rdata     = pins.rdata; // sampled while address still held
				nxt_st.rsp_valid = 1'b1;
				nxt_st.cs_n      = 1'b1;
				nxt_st.gate_n    = 1'b1;
				nxt_st.cnt       = FLOAT_W; // wait for the memory to release
				nxt_st.state     = asrc_pkg::ST_FLOAT;
			end
			asrc_pkg::ST_WSET: begin
				nxt_st.strobe_n = 1'b0; // write overlap of select and strobe
				nxt_st.drive    = 1'b1; // drive only after memory floated
				nxt_st.cnt      = STROBE_W;
				nxt_st.state    = asrc_pkg::ST_WSTB;
			end
			asrc_pkg::ST_WSTB: begin
				if (st_ff.cnt == CNT_ONE) begin
					nxt_st.strobe_n = 1'b1; // data and address held well past setup
					nxt_st.state    = asrc_pkg::ST_WHOLD;
				end else begin
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				end
			end
			asrc_pkg::ST_WHOLD: begin
				nxt_st.drive     = 1'b0; // release before memory could redrive
				nxt_st.cs_n      = 1'b1;
				nxt_st.rsp_valid = 1'b1;
				nxt_st.cnt       = FLOAT_W;
				nxt_st.state     = asrc_pkg::ST_FLOAT;
			end
			asrc_pkg::ST_FLOAT: begin
				if (st_ff.cnt <= RECOVER_W) begin
					nxt_st.state = asrc_pkg::ST_IDLE; // cycle spacing kept
				end else begin
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				end
			end
			default: begin
				nxt_st.state = asrc_pkg::ST_IDLE;
			end
		endcase
		if (!i_reset_n) begin
			nxt_st          = '0;
			nxt_st.state    = asrc_pkg::ST_IDLE;
			nxt_st.cs_n     = 1'b1;
			nxt_st.gate_n   = 1'b1;
			nxt_st.strobe_n = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_core_clk) begin
		st_ff <= nxt_st;
	end

	// ****************************************
	// pin stage
	// ****************************************
	assign pins.addr     = st_ff.addr; // 15-bit address into 32768 bytes
	assign pins.cs_n     = st_ff.cs_n;
	assign pins.gate_n   = st_ff.gate_n;
	assign pins.strobe_n = st_ff.strobe_n;
	assign pins.wdata    = st_ff.wdata;
	assign pins.drive    = st_ff.drive;

	asrc_pin_stage u_pins (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.pins       (pins.pin),
		.i_dq_in    (i_sram_dq),
		.o_dq_out   (o_sram_dq),
		.o_dq_oe    (o_sram_dq_oe),
		.o_addr     (o_sram_addr),
		.o_cs_n     (o_sram_cs_n),
		.o_gate_n   (o_sram_gate_n),
		.o_strobe_n (o_sram_strobe_n)
	);

	// request and answer
	assign o_req_ready = (st_ff.state == asrc_pkg::ST_IDLE);
	assign o_rsp_valid = st_ff.rsp_valid;
	assign o_rsp_rdata = st_ff.rdata;
endmodule : asrc_host
`default_nettype wire

// ### asrc_sram_model.sv
// model: byte-wide static memory behind the host pins
`default_nettype none
module asrc_sram_model #(
	parameter int ACC_NS = 12
) (
	input  wire logic [14:0] i_addr,
	input  wire logic        i_cs_n,
	input  wire logic        i_gate_n,
	input  wire logic        i_strobe_n,
	input  wire logic [7:0]  i_dq,
	output logic      [7:0]  o_dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_q [32768];
	logic [7:0] last_q = 8'h00;
	logic [7:0] data_q;
	logic       drv;
	// drive in read mode only, so a falling strobe floats at once
	assign drv = !i_cs_n && !i_gate_n && i_strobe_n;
	// slowest allowed access, follows the address with no strobe
	assign #(ACC_NS) data_q = mem_q[i_addr];
	// a released bus shows the inverted last byte
	assign o_dq = drv ? data_q : ~last_q;
	// store while select and strobe are both low
	always @* if (!i_cs_n && !i_strobe_n) mem_q[i_addr] = i_dq;
	// remember the last byte put out
	always @* if (drv) last_q = data_q;
endmodule // asrc_sram_model
`default_nettype wire

// ### asrc_host_chk.sv
// checker: pin sequencing checks on the sram host controller
`default_nettype none
module asrc_host_chk (
	input wire logic        i_core_clk,
	input wire logic        i_reset_n,
	input wire logic        i_req_valid,
	input wire logic        i_req_write,
	input wire logic        o_req_ready,
	input wire logic        o_rsp_valid,
	input wire logic [14:0] o_sram_addr,
	input wire logic        o_sram_cs_n,
	input wire logic        o_sram_gate_n,
	input wire logic        o_sram_strobe_n,
	input wire logic [7:0]  o_sram_dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// accepted requests and the strobe pulse
	sequence s_rd; i_req_valid && o_req_ready && !i_req_write; endsequence
	sequence s_wr; i_req_valid && o_req_ready && i_req_write; endsequence
	sequence s_pulse; !o_sram_strobe_n ##1 o_sram_strobe_n; endsequence
	AST_RD_STROBE: assert property (!o_sram_gate_n |-> o_sram_strobe_n)
		else $error("strobe low in read");
	AST_ADDR_HELD: assert property (!o_sram_cs_n && !$past(o_sram_cs_n) |-> $stable(o_sram_addr))
		else $error("address moved while selected");
	AST_STB_SETUP: assert property ($fell(o_sram_strobe_n) |-> !$past(o_sram_cs_n) && $stable(o_sram_addr))
		else $error("strobe before address");
	AST_STB_PULSE: assert property ($fell(o_sram_strobe_n) |-> s_pulse ##0 !o_sram_cs_n)
		else $error("strobe pulse wrong");
	AST_DATA_ON: assert property (!o_sram_strobe_n || $rose(o_sram_strobe_n) |-> o_sram_dq_oe == 8'hff)
		else $error("write data missing");
	AST_NO_CLASH: assert property (|o_sram_dq_oe |-> o_sram_gate_n)
		else $error("gate low while driving");
	AST_GAP: assert property ($rose(o_sram_cs_n) |=> o_sram_cs_n)
		else $error("cycles too close");
	AST_RD_ANS: assert property (s_rd |-> ##5 o_rsp_valid)
		else $error("read answer late");
	AST_WR_ANS: assert property (s_wr |-> ##4 o_rsp_valid)
		else $error("write answer late");
endmodule // asrc_host_chk
bind asrc_host asrc_host_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
	.i_req_write(i_req_write), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_sram_addr(o_sram_addr),
	.o_sram_cs_n(o_sram_cs_n), .o_sram_gate_n(o_sram_gate_n), .o_sram_strobe_n(o_sram_strobe_n),
	.o_sram_dq_oe(o_sram_dq_oe));
`default_nettype wire

// ### asrc_host_tb_top.sv
// testbench: sram host controller against a memory model
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module asrc_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        valid = 1'b0;
	logic        write = 1'b0;
	logic [14:0] addr = 15'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        ready, rsp, cs_n, gate_n, strobe_n;
	logic [7:0]  rdata, host_dq, host_oe, mem_dq, bus;
	logic [14:0] pin_addr;
	int          miscompares = 0;
	int          comparisons = 0;
	// clock and bus level seen by both sides
	always #25 clk = ~clk;
	assign bus = (host_dq & host_oe) | (mem_dq & ~host_oe);
	asrc_host u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_req_valid(valid), .i_req_write(write),
		.i_req_addr(addr), .i_req_wdata(wdata), .o_req_ready(ready), .o_rsp_valid(rsp), .o_rsp_rdata(rdata),
		.o_sram_addr(pin_addr), .o_sram_cs_n(cs_n), .o_sram_gate_n(gate_n), .o_sram_strobe_n(strobe_n),
		.i_sram_dq(bus), .o_sram_dq(host_dq), .o_sram_dq_oe(host_oe));
	asrc_sram_model u_mem (.i_addr(pin_addr), .i_cs_n(cs_n), .i_gate_n(gate_n), .i_strobe_n(strobe_n),
		.i_dq(bus), .o_dq(mem_dq));
	// one request through the handshake, answer latency checked
	task automatic do_req(input logic w, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 1; // count up to the edge that samples the answer
		while (ready !== 1'b1) @(posedge clk) #2;
		valid = 1'b1;
		write = w;
		addr = a;
		wdata = d;
		@(posedge clk) #2;
		valid = 1'b0;
		while (rsp !== 1'b1 && n < 9) begin
			@(posedge clk) #2;
			n++;
		end
		`CHK("latency", w ? 4 : 5, n)
		q = rdata;
	endtask
	// pins idle after reset
	task automatic t_idle();
		`CHK("cs_n", 1'b1, cs_n)
		`CHK("strobe_n", 1'b1, strobe_n)
		`CHK("dq_oe", 8'h00, host_oe)
		`CHK("ready", 1'b1, ready)
		$display("t_idle done");
	endtask
	// corner and alternating-bit addresses written, read back, then 7fff overwritten and read again
	task automatic t_rw();
		logic [14:0] ad [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
		logic [7:0]  dt [4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
		logic [7:0]  q;
		foreach (ad[i]) do_req(1'b1, ad[i], dt[i], q);
		foreach (ad[i]) begin
			do_req(1'b0, ad[i], 8'h00, q);
			`CHK("rdata", dt[i], q)
		end
		do_req(1'b1, 15'h7fff, 8'h81, q);
		do_req(1'b0, 15'h7fff, 8'h00, q);
		`CHK("rdata", 8'h81, q)
		$display("t_rw done");
	endtask
	// request held high while busy is taken only when ready
	task automatic t_busy();
		int k;
		k = 0;
		while (ready !== 1'b1) @(posedge clk) #2;
		valid = 1'b1;
		write = 1'b0;
		addr = 15'h2aaa;
		repeat (12) begin
			@(posedge clk) #2;
			k += int'(rsp === 1'b1);
		end
		valid = 1'b0;
		`CHK("answers", 2, k)
		`CHK("rdata", 8'hff, rdata)
		$display("t_busy done");
	endtask
	// reset in mid write leaves pins idle and the byte unwritten
	task automatic t_reset();
		logic [7:0] q;
		while (ready !== 1'b1) @(posedge clk) #2;
		valid = 1'b1;
		write = 1'b1;
		addr = 15'h5555;
		wdata = 8'h77;
		@(posedge clk) #2;
		valid = 1'b0;
		@(posedge clk) #2;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#2 rst_n = 1'b1;
		`CHK("cs_n", 1'b1, cs_n)
		`CHK("strobe_n", 1'b1, strobe_n)
		`CHK("gate_n", 1'b1, gate_n)
		`CHK("dq_oe", 8'h00, host_oe)
		`CHK("ready", 1'b1, ready)
		`CHK("rsp", 1'b0, rsp)
		do_req(1'b0, 15'h5555, 8'h00, q);
		`CHK("rdata", 8'h00, q)
		$display("t_reset done");
	endtask
	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		#2 rst_n = 1'b1;
		t_idle();
		t_rw();
		t_busy();
		t_reset();
		close_out();
	end
	// watchdog well past the expected run
	initial begin
		#(400 * 50);
		miscompares++;
		close_out();
	end
endmodule // asrc_host_tb_top
`default_nettype wire
